// file: common/tsr_pkg.sv
// constants and carrier types for the temperature sensor serial register block
package tsr_pkg;

  // ===========================================================
  // serial word framing
  localparam int          WORD_BITS   = 16;
  localparam logic [3:0]  LAST_BIT    = 4'hf;
  localparam logic [3:0]  DRIVE_BITS  = 4'he;
  localparam logic [3:0]  MIN_WR_BITS = 4'h8;

  // ===========================================================
  // mode control
  localparam logic [7:0]  SHUT_CODE   = 8'hff;
  localparam logic [15:0] MODE_RESET  = 16'h0000;

  // ===========================================================
  // temperature result
  localparam int          RESULT_BITS  = 13;
  localparam logic [12:0] RESULT_RESET = 13'h1fe0;
  localparam logic [1:0]  UNDEF_FILL   = 2'h0;
  localparam logic [7:0]  ID_LOW_FILL  = 8'h00;

  // ===========================================================
  // timing
  localparam int CLK_HZ       = 10000000;
  localparam int CONV_TIME_MS = 300;
  localparam int CONV_CYC     = CONV_TIME_MS * (CLK_HZ / 1000);

  // ===========================================================
  // carriers
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic sio;
  } tsr_pins_t;

  typedef struct packed {
    logic [12:0] result;
    logic        done;
    logic [1:0]  undef;
  } tsr_temp_t;

  typedef struct packed {
    logic [7:0] maker;
    logic [7:0] zero;
  } tsr_id_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } tsr_state_t;

endpackage

// file: logic/tsr_top.sv
// serial register interface of the temperature sensor, device side
// Behaviour
// - identification word is presented only while the device is in shutdown
// - after identification, a write of 8 to 16 zero bits restores conversion
// - about 300 ms pass between a conversion and its data being available
// - mode register is written only over the link and never read back
// - temperature and identification words are read-only; writes never change them
// - shutdown when mode low byte is all ones, else continuous conversion
// - after reset conversion runs and mode low byte is zero
// - serial interface keeps working during shutdown
// - temperature word holds 13-bit signed result in bits 15 to 3
// - temperature bits 1 and 0 are undefined and shifted with data line released
// - bit 2 reads zero until the first conversion completes, then one
// - identification: maker code in 15 to 8, zeros in 7 to 2, 1 to 0 released
// - upper byte of a mode write is ignored
// - clock edges ignored while select high; falling select starts, rising ends
// - first bit driven at select fall, later bits on clock fall, sampled on rise
// - data line released after 14 meaningful bits
// - first 16 clocks carry temperature out, next 16 carry mode word in
`timescale 1ns/100ps

module tsr_top
  import tsr_pkg::*;
#(
  parameter int         CONV_CYCLES = CONV_CYC,
  // arbitrary maker code, neutral value
  parameter logic [7:0] MAKER_CODE  = 8'h3c
) (
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // serial link pins
  input  wire logic              CS_N_I,
  input  wire logic              SCK_I,
  input  wire logic              SIO_I,
  output logic                   SIO_O,
  output logic                   SIO_OE_O,
  // converter side
  input  wire logic [12:0]       TEMP_SAMPLE_I,
  // status
  output logic                   SHUTDOWN_O,
  output logic                   FIRST_DONE_O
);

  localparam int CW = $clog2(CONV_CYCLES + 1);

  // ===========================================================
  // helpers
  // only the low byte selects the mode
  function automatic logic is_shut(input logic [15:0] w);
    is_shut = (w[7:0] == SHUT_CODE);
  endfunction

  // ===========================================================
  // declarations
  tsr_pins_t   pin_s1;
  tsr_pins_t   pin_s2;
  tsr_pins_t   pin_s3;
  tsr_state_t  state;
  logic [3:0]  bit_cnt;
  logic [3:0]  out_idx;
  logic        pre;
  logic [15:0] rd_word;
  logic        rd_is_id;
  logic [15:0] wr_sh;
  logic [15:0] mode;
  logic [12:0] temp_reg;
  logic        first_done;
  logic [CW-1:0] conv_cnt;
  logic        conv_tick;
  logic        shutdown;
  logic        cs_fall;
  logic        cs_rise;
  logic        sck_rise;
  logic        sck_fall;
  logic        link_on;
  logic [15:0] next_mode;
  tsr_temp_t   temp_word;
  tsr_id_t     id_word;

  // ===========================================================
  // pin synchronisers
  // stage one feeds stage two only
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pin_s1 <= '{cs_n: 1'b1, sck: 1'b0, sio: 1'b0};
      pin_s2 <= '{cs_n: 1'b1, sck: 1'b0, sio: 1'b0};
      pin_s3 <= '{cs_n: 1'b1, sck: 1'b0, sio: 1'b0};
    end else begin
      pin_s1 <= '{cs_n: CS_N_I, sck: SCK_I, sio: SIO_I};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ===========================================================
  // edge detection
  assign link_on  = !pin_s2.cs_n && (state != ST_IDLE);
  assign cs_fall  = pin_s3.cs_n && !pin_s2.cs_n;
  assign cs_rise  = !pin_s3.cs_n && pin_s2.cs_n;
  assign sck_rise = link_on && !pin_s3.sck && pin_s2.sck;
  assign sck_fall = link_on && pin_s3.sck && !pin_s2.sck;

  // ===========================================================
  // readable words, never written by the link
  assign temp_word = '{result: temp_reg, done: first_done, undef: UNDEF_FILL};
  assign id_word   = '{maker: MAKER_CODE, zero: ID_LOW_FILL};
  assign next_mode = {wr_sh[14:0], pin_s2.sio};
  assign shutdown  = is_shut(mode);

  // ===========================================================
  // transaction sequencer
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      out_idx  <= 4'h0;
      pre      <= 1'b0;
      rd_word  <= 16'h0000;
      rd_is_id <= 1'b0;
      wr_sh    <= 16'h0000;
    end else if (pin_s2.cs_n) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      pre      <= 1'b0;
    end else if (cs_fall) begin
      // first word of a transaction is always the temperature
      state    <= ST_READ;
      bit_cnt  <= 4'h0;
      out_idx  <= 4'h0;
      pre      <= 1'b0;
      rd_word  <= temp_word;
      rd_is_id <= 1'b0;
    end else begin
      case (state)
        ST_READ: begin
          if (sck_rise) begin
            if (bit_cnt == LAST_BIT) begin
              state   <= ST_WRITE;
              bit_cnt <= 4'h0;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          if (sck_fall) begin
            if (pre) begin
              pre <= 1'b0;
            end else if (out_idx != LAST_BIT) begin
              out_idx <= out_idx + 4'h1;
            end
          end
        end
        ST_WRITE: begin
          if (sck_rise) begin
            wr_sh <= next_mode;
            if (bit_cnt == LAST_BIT) begin
              // next read sees the mode just written
              state    <= ST_READ;
              bit_cnt  <= 4'h0;
              out_idx  <= 4'h0;
              pre      <= 1'b1;
              rd_is_id <= is_shut(next_mode);
              rd_word  <= is_shut(next_mode) ? 16'(id_word) : 16'(temp_word);
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ===========================================================
  // mode control register, write only
  // no read path exists; upper byte stored but unused
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mode <= MODE_RESET;
    end else if (state == ST_WRITE && sck_rise && !pin_s2.cs_n && bit_cnt == LAST_BIT) begin
      mode <= next_mode;
    end else if (cs_rise && state == ST_WRITE && bit_cnt >= MIN_WR_BITS) begin
      // short write: last eight bits form the low byte
      mode <= wr_sh;
    end
  end

  // ===========================================================
  // conversion timing
  // restarting the count on wake keeps data age near one period
  assign conv_tick = !shutdown && (conv_cnt == CW'(CONV_CYCLES - 1));

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      conv_cnt <= '0;
    end else if (shutdown || conv_tick) begin
      conv_cnt <= '0;
    end else begin
      conv_cnt <= conv_cnt + CW'(1);
    end
  end

  // the output word is refreshed even mid-transaction; loaded copy stays
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      temp_reg <= RESULT_RESET;
    end else if (conv_tick) begin
      temp_reg <= TEMP_SAMPLE_I;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      first_done <= 1'b0;
    end else if (conv_tick) begin
      first_done <= 1'b1;
    end
  end

  // ===========================================================
  // pin and status outputs
  // one cycle behind the sequencer, well inside a half clock period
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SIO_O    <= 1'b0;
      SIO_OE_O <= 1'b0;
    end else begin
      SIO_O    <= rd_word[4'(WORD_BITS - 1) - out_idx];
      SIO_OE_O <= (state == ST_READ) && !pin_s2.cs_n && !pre
                  && (out_idx < DRIVE_BITS);
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      SHUTDOWN_O   <= 1'b0;
      FIRST_DONE_O <= 1'b0;
    end else begin
      SHUTDOWN_O   <= shutdown;
      FIRST_DONE_O <= first_done;
    end
  end

  // ===========================================================
  // checks
  id_shut_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (state == ST_READ && rd_is_id) |-> shutdown)
    else $error("id word presented outside shutdown");

  release_tail_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (state == ST_READ && out_idx >= DRIVE_BITS) |=> !SIO_OE_O)
    else $error("data line driven past meaningful bits");

  first_bit_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (cs_fall && pin_s2.cs_n == 1'b0) ##1 !pin_s2.cs_n
    |=> SIO_OE_O && SIO_O == rd_word[WORD_BITS-1])
    else $error("first bit not driven after select fall");

  temp_layout_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    cs_fall |=> rd_word == {$past(temp_reg), $past(first_done), UNDEF_FILL})
    else $error("temperature word layout wrong");

  shut_decode_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (mode[7:0] == SHUT_CODE) [*2] |-> SHUTDOWN_O)
    else $error("shutdown not reported for all-ones low byte");

  conv_stop_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    shutdown |=> $stable(temp_reg) && conv_cnt == '0)
    else $error("conversion ran during shutdown");

  flag_rise_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    $rose(first_done) |-> $past(conv_tick))
    else $error("first-done flag set without conversion");

  mode_short_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (cs_rise && state == ST_WRITE && bit_cnt < MIN_WR_BITS) |=> $stable(mode))
    else $error("short write changed mode");

  mode_apply_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (cs_rise && state == ST_WRITE && bit_cnt >= MIN_WR_BITS) |=> mode == $past(wr_sh))
    else $error("mode not applied at select rise");

  word_turn_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    (state == ST_READ && sck_rise && !pin_s2.cs_n && bit_cnt == LAST_BIT)
    |=> state == ST_WRITE && bit_cnt == 4'h0)
    else $error("read word did not turn to write after 16 bits");

  idle_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
    pin_s2.cs_n [*2] |-> state == ST_IDLE && !SIO_OE_O)
    else $error("activity while select high");

endmodule

// file: dv/tsr_host.sv
// host model: serial link master with one shared data line
`timescale 1ns/100ps
module tsr_host (
  // clock
  input  wire logic        clk_i,
  // device data pin
  input  wire logic        sio_o_i,
  input  wire logic        sio_oe_i,
  // link pins
  output logic             cs_n_o,
  output logic             sck_o,
  output logic             sio_line_o,
  // last word read
  output logic [15:0]      rd_o,
  output logic [15:0]      oe_o
);
  logic host_oe;
  logic host_d;
  logic last = 1'b0;
  event rd_ev;

  // ===========================================================
  // wire level: a released line shows the inverse of its last driven value
  assign sio_line_o = sio_oe_i ? sio_o_i : (host_oe ? host_d : ~last);
  always @(posedge clk_i) if (sio_oe_i | host_oe) last <= sio_line_o;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    host_oe = 1'b0;
    host_d = 1'b0;
  end

  // ===========================================================
  // link tasks, pins change just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  task automatic begin_xfer();
    cs_n_o = 1'b0;
  endtask
  // data line already released by the last word task
  task automatic end_xfer();
    cs_n_o = 1'b1;
    tick(4);
  endtask
  // clock pulses with select high must be ignored
  task automatic stray(input int n);
    repeat (n) begin
      sck_o = 1'b1;
      tick(4);
      sck_o = 1'b0;
      tick(4);
    end
  endtask
  task automatic rd_word();
    for (int i = 15; i >= 0; i--) begin
      tick(4);
      rd_o[i] = sio_line_o;
      oe_o[i] = sio_oe_i;
      sck_o = 1'b1;
      tick(4);
      sck_o = 1'b0;
    end
    -> rd_ev;
  endtask
  task automatic wr_bits(input logic [15:0] d, input int n);
    host_oe = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      host_d = d[i];
      tick(4);
      sck_o = 1'b1;
      tick(4);
      sck_o = 1'b0;
    end
    host_oe = 1'b0;
  endtask
endmodule

// file: dv/temp_sensor_serial_regs_test.sv
// self-checking bench for the serial register block
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin \
  n_checks++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("mismatch at %0t: %s", $time, msg); \
  end \
end
module temp_sensor_serial_regs_test;
  import tsr_pkg::*;
  // short conversion period keeps the run brief
  localparam int         CONV_N = 50;
  // arbitrary maker code
  localparam logic [7:0] MAKER  = 8'h5a;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [12:0] sample;
  logic        cs_n, sck, line, sio_o, sio_oe, shut, fdone;
  logic [15:0] rd, oe, tword;
  logic [7:0]  code;
  logic [31:0] lfsr = 32'h5f43;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int          error_cnt = 0;
  int          n_checks = 0;

  always #50 clk = ~clk;

  tsr_top #(.CONV_CYCLES(CONV_N), .MAKER_CODE(MAKER)) dut (
    .CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .SCK_I(sck), .SIO_I(line),
    .SIO_O(sio_o), .SIO_OE_O(sio_oe), .TEMP_SAMPLE_I(sample),
    .SHUTDOWN_O(shut), .FIRST_DONE_O(fdone));
  tsr_host host (.clk_i(clk), .sio_o_i(sio_o), .sio_oe_i(sio_oe), .cs_n_o(cs_n),
    .sck_o(sck), .sio_line_o(line), .rd_o(rd), .oe_o(oe));

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // ===========================================================
  // expectations: bits 1:0 released, never compared by value
  task automatic exp_word(input logic [15:0] v);
    exp_q.push_back({1'b1, 16'hfffc, v & 16'hfffc});
    host.rd_word();
  endtask
  // a word with no note behind it is itself a mismatch
  always @(host.rd_ev) begin
    e = exp_q.pop_front();
    if (e[32] !== 1'b1) begin
      error_cnt++;
      $display("mismatch at %0t: read word without expectation", $time);
    end else begin
      `CHK(oe, e[31:16], "data line enable")
      `CHK(rd & 16'hfffc, e[15:0], "read word")
    end
  end

  task automatic close_out();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ===========================================================
  // watchdog, about seven and a half times the expected run
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  // ===========================================================
  // main sequence
  initial begin
    sample = 13'h0000;
    repeat (4) @(posedge clk);
    #5 rst = 1'b0;
    host.tick(3);
    `CHK(shut, 1'b0, "shutdown after reset")
    `CHK(fdone, 1'b0, "first done after reset")
    // select must fall before the first conversion
    host.stray(2);
    host.begin_xfer();
    exp_word({RESULT_RESET, 3'h0});
    host.end_xfer();
    lfsr = next_rand(lfsr);
    sample = lfsr[12:0];
    tword = {lfsr[12:0], 3'h4};
    host.tick(CONV_N + 5);
    `CHK(fdone, 1'b1, "first done set")
    // every contiguous low-order-ones code, random upper byte
    for (int k = 0; k <= 8; k++) begin
      code = 8'hff >> (8 - k);
      lfsr = next_rand(lfsr);
      host.begin_xfer();
      exp_word(tword);
      host.wr_bits({lfsr[7:0], code}, 16);
      `CHK(shut, code == SHUT_CODE, "mode from low byte")
      exp_word(code == SHUT_CODE ? {MAKER, 8'h00} : tword);
      host.wr_bits(16'h0000, 16 - k);
      host.end_xfer();
      `CHK(shut, 1'b0, "back to conversion")
    end
    // a write shorter than eight bits leaves the mode alone
    host.begin_xfer();
    exp_word(tword);
    host.wr_bits({lfsr[15:8], SHUT_CODE}, 16);
    exp_word({MAKER, 8'h00});
    host.wr_bits(16'h0000, 7);
    host.end_xfer();
    `CHK(shut, 1'b1, "short write refused")
    // held result stays readable while shut down
    host.begin_xfer();
    exp_word(tword);
    host.wr_bits(16'h0000, 16);
    host.end_xfer();
    `CHK(shut, 1'b0, "exit from shutdown")
    close_out();
  end
endmodule
